// ===== design/comparator_channel_map.vh
/*
 register offsets, field positions, reset values and timing constants of
 one comparator channel. definitions only; included by the control module.
*/
`ifndef COMPARATOR_CHANNEL_MAP_VH
`define COMPARATOR_CHANNEL_MAP_VH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define ADDR_COMPARATOR_CONTROL 12'h000
`define ADDR_COMPARATOR_STATUS 12'h004

// ----------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------
`define BIT_ENABLE 0
`define BIT_SINGLE 2
`define POS_NEG_SEL_LO 8
`define POS_NEG_SEL_HI 10
`define POS_POS_SEL_LO 12
`define POS_POS_SEL_HI 13
`define BIT_SWAP 15
`define POS_OUT_SEL_LO 16
`define POS_OUT_SEL_HI 17
`define BIT_HYSTERESIS_ENABLE 19
`define CONTROL_RESET 32'h00000000
`define CONTROL_LOCKED_MASK 32'h000BB700

// ----------------------------------------------------------------------
// output routing codes
// ----------------------------------------------------------------------
`define OUT_OFF 2'h0
`define OUT_ASYNC 2'h1
`define OUT_SYNC 2'h2

// ----------------------------------------------------------------------
// filter: result must be stable this many clocks before sync output moves
// ----------------------------------------------------------------------
`define FILTER_TIME_NS 30
`define CLK_PERIOD_NS 10
`define FILTER_CYCLES ((`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== design/comparator_sync_filter.v
/*
 two-flop synchroniser and consecutive-count stability filter for the raw
 comparator result. assumes raw input is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`include "comparator_channel_map.vh"

module comparator_sync_filter (
   input wire clk_sys,
   input wire rst_b,
   input wire rawIn,
   output wire filtOut
);

   reg syncA_ff;
   reg syncB_ff;
   reg filt_ff;
   reg [3:0] stableCnt_ff;
   reg [3:0] nxt_stableCnt;
   reg nxt_filt;

   // ----------------------------------------------------------------------
   // synchroniser and filter
   // ----------------------------------------------------------------------
   always @* begin
      nxt_filt = filt_ff;
      nxt_stableCnt = 4'h0;
      if (syncB_ff != filt_ff) begin
         nxt_stableCnt = stableCnt_ff + 4'h1;
         if (stableCnt_ff == (`FILTER_CYCLES - 1)) begin
            nxt_filt = syncB_ff;
            nxt_stableCnt = 4'h0;
         end
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         syncA_ff <= 1'b0;
         syncB_ff <= 1'b0;
         filt_ff <= 1'b0;
         stableCnt_ff <= 4'h0;
      end else begin
         syncA_ff <= rawIn;
         syncB_ff <= syncA_ff;
         filt_ff <= nxt_filt;
         stableCnt_ff <= nxt_stableCnt;
      end
   end

   assign filtOut = filt_ff;

endmodule // comparator_sync_filter

// ===== design/comparator_channel_control.v
/*
 control of one analog comparator channel: apb register slave, input
 routing, swap/invert, hysteresis enable and output pin routing.
 assumes the analog core takes its selects as levels and returns a raw
 asynchronous result; apb master is clocked by clk_sys.
*/
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "comparator_channel_map.vh"

module comparator_channel_control (
   input wire clk_sys,
   input wire rst_b,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [3:0] inputPins,
   input wire [7:0] negSources,
   input wire rawResult,
   output wire analogPosIn,
   output wire analogNegIn,
   output wire hysteresisOn,
   output wire comparatorEnable,
   output wire singleShot,
   output wire pinOut,
   output wire pinOutEn
);

   reg [31:0] control_ff;
   reg [31:0] nxt_control;
   reg [31:0] rdata_ff;
   reg [31:0] nxt_rdata;
   reg slverr_ff;
   wire filtResult;
   wire unitResult;
   wire [31:0] lockMask;
   wire wrAccess;
   wire rdAccess;
   wire mapped;
   wire [1:0] outSel;

   function isMapped;
      input [11:0] addr;
      begin
         isMapped = (addr == `ADDR_COMPARATOR_CONTROL) || (addr == `ADDR_COMPARATOR_STATUS);
      end
   endfunction

   // ----------------------------------------------------------------------
   // apb slave: zero wait states, unmapped address gives pslverr
   // ----------------------------------------------------------------------
   assign wrAccess = psel && penable && pwrite;
   assign rdAccess = psel && !penable && !pwrite;
   assign mapped = isMapped(paddr);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   assign lockMask = control_ff[`BIT_ENABLE] ? `CONTROL_LOCKED_MASK : 32'h00000000;

   always @* begin
      nxt_control = control_ff;
      if (wrAccess && (paddr == `ADDR_COMPARATOR_CONTROL)) begin
         nxt_control = (pwdata & ~lockMask) | (control_ff & lockMask);
         nxt_control = nxt_control & (`CONTROL_LOCKED_MASK | 32'h00000005);
      end
   end

   always @* begin
      nxt_rdata = rdata_ff;
      if (rdAccess) begin
         if (paddr == `ADDR_COMPARATOR_CONTROL) begin
            nxt_rdata = control_ff;
         end else if (paddr == `ADDR_COMPARATOR_STATUS) begin
            nxt_rdata = {30'h00000000, filtResult, unitResult};
         end else begin
            nxt_rdata = 32'h00000000;
         end
      end
   end

   always @(posedge clk_sys) begin
      if (!rst_b) begin
         control_ff <= `CONTROL_RESET;
         rdata_ff <= 32'h00000000;
         slverr_ff <= 1'b0;
      end else begin
         control_ff <= nxt_control;
         rdata_ff <= nxt_rdata;
         slverr_ff <= pslverr;
      end
   end

   assign prdata = rdata_ff;

   // ----------------------------------------------------------------------
   // analog routing
   // ----------------------------------------------------------------------
   wire posPin;
   wire negPin;
   assign posPin = inputPins[control_ff[`POS_POS_SEL_HI:`POS_POS_SEL_LO]];
   assign negPin = negSources[control_ff[`POS_NEG_SEL_HI:`POS_NEG_SEL_LO]];
   assign analogPosIn = control_ff[`BIT_SWAP] ? negPin : posPin;
   assign analogNegIn = control_ff[`BIT_SWAP] ? posPin : negPin;
   assign unitResult = rawResult ^ control_ff[`BIT_SWAP];

   assign hysteresisOn = control_ff[`BIT_HYSTERESIS_ENABLE] && !control_ff[`BIT_SINGLE];
   assign comparatorEnable = control_ff[`BIT_ENABLE];
   assign singleShot = control_ff[`BIT_SINGLE];

   comparator_sync_filter u_filter (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .rawIn(unitResult),
      .filtOut(filtResult)
   );

   // ----------------------------------------------------------------------
   // output pin routing; async path deliberately unregistered
   // ----------------------------------------------------------------------
   assign outSel = control_ff[`POS_OUT_SEL_HI:`POS_OUT_SEL_LO];
   assign pinOut = (outSel == `OUT_ASYNC) ? unitResult :
                   (outSel == `OUT_SYNC) ? filtResult : 1'b0;
   assign pinOutEn = (outSel == `OUT_ASYNC) || (outSel == `OUT_SYNC);

endmodule // comparator_channel_control

// ===== dv/comparator_core_model.sv
/* behavioural analog comparator core facing the channel control.
   assumes digital levels on both inputs; result low while disabled. */
`timescale 1ns/1ps
module comparator_core_model (
   input wire logic analogPosIn,
   input wire logic analogNegIn,
   input wire logic comparatorEnable,
   output logic rawResult
);
   // ------
   // comparison
   // ------
   // small delay keeps the result off the bus clock edge, like a real core
   assign #2 rawResult = comparatorEnable & analogPosIn & ~analogNegIn;
endmodule // comparator_core_model

// ===== dv/comparator_channel_chk.sv
/* port checker for comparator_channel_control.
   assumes one clock domain; bound to the design top below. */
`timescale 1ns/1ps
module comparator_channel_chk (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] inputPins,
   input wire logic [7:0] negSources,
   input wire logic rawResult,
   input wire logic analogPosIn,
   input wire logic analogNegIn,
   input wire logic hysteresisOn,
   input wire logic comparatorEnable,
   input wire logic singleShot,
   input wire logic pinOut,
   input wire logic pinOutEn
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // ------
   // locks, routing and apb response
   // ------
   hysteresis_enable_single_a: assert property (hysteresisOn |-> !singleShot)
      else $error("hysteresis in single shot");
   hysteresis_enable_lock_a: assert property (comparatorEnable && $past(comparatorEnable)
      && $stable(singleShot) |-> $stable(hysteresisOn)) else $error("hysteresis moved");
   out_lock_a: assert property (comparatorEnable && $past(comparatorEnable)
      |-> $stable(pinOutEn)) else $error("routing moved");
   input_lock_a: assert property (comparatorEnable && $past(comparatorEnable)
      && $stable(inputPins) && $stable(negSources)
      |-> $stable(analogPosIn) && $stable(analogNegIn)) else $error("inputs moved");
   off_low_a: assert property (!pinOutEn |-> !pinOut)
      else $error("pin driven while off");
   ready_now_a: assert property (psel && penable |-> pready)
      else $error("access stalled");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access");
   pin_cause_a: assert property (comparatorEnable && $past(comparatorEnable)
      && pinOutEn && $changed(pinOut)
      |-> $changed(rawResult) || $past(rawResult, 2) == $past(rawResult, 3))
      else $error("pin moved without cause");
   cover property (comparatorEnable && pinOutEn && pinOut);
   cover property (hysteresisOn);
   cover property (pslverr);
endmodule // comparator_channel_chk

bind comparator_channel_control comparator_channel_chk i_comparator_channel_chk (.*);

// ===== dv/comparator_channel_control_tb.sv
/* directed bench for comparator_channel_control over apb.
   assumes the core model answers from the routed inputs. */
`timescale 1ns/1ps
module comparator_channel_control_tb;
   logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, analogPosIn, analogNegIn, hysteresisOn, comparatorEnable;
   logic singleShot, pinOut, pinOutEn, rawResult;
   logic [3:0] inputPins = 4'h0;
   logic [7:0] negSources = 8'h00;
   int miscompares = 0, cmp_count = 0;
   always #5 clk_sys = ~clk_sys;
   comparator_channel_control i_comparator_channel_control (.*);
   comparator_core_model i_comparator_core_model (.*);
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys) penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      // the write lands at the access edge; let one edge pass so outputs show it
      @(posedge clk_sys);
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // ------
   // directed sequence
   // ------
   initial begin
      logic [31:0] c;
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      apb(0, 12'h000, 0);
      chk("ctrl reset", 0, rd);
      for (int i = 0; i < 16; i++) begin
         c = {13'h0001, 3'h0, i[3], 1'b0, i[1:0], 1'b0, i[2:0], 8'h00};
         inputPins <= 4'h1 << i[1:0];
         negSources <= ~(8'h01 << i[2:0]);
         apb(1, 12'h000, c);
         apb(0, 12'h000, 0);
         chk("ctrl", c, rd);
         chk("pos", !i[3], analogPosIn);
         chk("neg", i[3], analogNegIn);
         chk("hysteresis_enable", 1, hysteresisOn);
      end
      apb(1, 12'h000, 32'h00080004);
      chk("hysteresis_enable single", 0, hysteresisOn);
      chk("single", 1, singleShot);
      inputPins <= 4'h1;
      negSources <= 8'h00;
      apb(1, 12'h000, 32'h00090000);
      apb(1, 12'h000, 32'h00090001);
      chk("enable", 1, comparatorEnable);
      chk("async pin", 1, pinOut);
      apb(1, 12'h000, 32'h00000001);
      apb(0, 12'h000, 0);
      chk("locked", 32'h00090001, rd);
      apb(1, 12'h000, 32'h00000000);
      apb(1, 12'h000, 32'h00030000);
      chk("code 3 off", 0, pinOutEn);
      apb(1, 12'h000, 32'h00020000);
      apb(1, 12'h000, 32'h00020001);
      repeat (10) @(posedge clk_sys);
      chk("sync pin", 1, pinOut);
      inputPins <= 4'h0;
      repeat (2) @(posedge clk_sys);
      chk("sync lag", 1, pinOut);
      repeat (10) @(posedge clk_sys);
      chk("sync low", 0, pinOut);
      apb(0, 12'h008, 0);
      chk("unmapped data", 32'h0, rd);
      chk("unmapped err", 32'h1, {31'h0, err});
      test_done;
   end
   initial begin
      #100000;
      miscompares++;
      test_done;
   end
endmodule // comparator_channel_control_tb
